/* verilog/tmr2_ctrl.v */
// timer-2 capture/reload control with axi4-lite register slave
// assumes pins asynchronous to aclk; baud consumer on aclk
//
// Contract
// - rx baud source takes other timer overflow when its select is clear, else ours.
// - tx baud source takes other timer overflow when its select is clear, else ours.
// - with trigger enabled and both baud selects clear, a trigger fall causes capture or reload.
// - the count advances only while run control is one.
// - in timer mode the count increments once every two clocks.
// - in counter mode the count increments on each count pin fall.
// - in reload mode the count reloads on overflow and on an enabled trigger fall.
// - in capture mode an enabled trigger fall copies the count into the reload register.
// - with a baud select set, capture select is ignored and overflow always reloads.
// - overflow flag sets on overflow unless a baud select is set; software clears it.
// - trigger flag sets when a trigger fall causes capture or reload; software clears it.
// - count is low and high bytes, software readable and writable, reset zero.
// - reload/capture register is readable and writable and resets zero.
`timescale 1ns/10ps
`include "tmr2_map.vh"
module tmr2_ctrl (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire ext_trigger_pin,
    input wire count_input_pin,
    // baud clocks
    input wire timer1_overflow,
    output reg rx_baud_tick,
    output reg tx_baud_tick
);
    // address decode shared by read and write
    function tmr2_hit;
        input [7:0] a;
        begin
            tmr2_hit = (a == `TMR2_OFF_CTRL) || (a == `TMR2_OFF_RCL) ||
                (a == `TMR2_OFF_RCH) || (a == `TMR2_OFF_CNTL) || (a == `TMR2_OFF_CNTH);
        end
    endfunction

    reg [7:0] ctrl_q;
    reg [15:0] cnt_q;
    reg [15:0] rc_q;
    reg [1:0] trg_sync_q;
    reg [1:0] cin_sync_q;
    reg trg_prev_q;
    reg cin_prev_q;
    reg div_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] awaddr_q;
    reg [7:0] wdata_q;
    reg wstrb_q;

    // control fields; the two flag bits are only written in the counter process
    wire rclk_sel = ctrl_q[`TMR2_BIT_RCLK];
    wire tx_baud_source_select_sel = ctrl_q[`TMR2_BIT_TX_BAUD_SOURCE_SELECT];
    wire exen = ctrl_q[`TMR2_BIT_EXEN];
    wire run = ctrl_q[`TMR2_BIT_RUN];
    wire ct_sel = ctrl_q[`TMR2_BIT_CT];
    wire cp_sel = ctrl_q[`TMR2_BIT_CP];
    wire baud_mode = rclk_sel | tx_baud_source_select_sel;

    // falls from the second sync stage only
    wire trg_fall = trg_prev_q & ~trg_sync_q[1];
    wire cin_fall = cin_prev_q & ~cin_sync_q[1];
    wire trig_evt = exen & trg_fall & ~baud_mode;
    wire tick = run & (ct_sel ? cin_fall : div_q);
    wire ovf = tick & (cnt_q == `TMR2_CNT_MAX);
    wire capture = trig_evt & cp_sel;
    wire reload = ovf & (~cp_sel | baud_mode) | (trig_evt & ~cp_sel);

    // write channel handshake: take address and data in either order
    wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    wire wr_ok = tmr2_hit(awaddr_q);

    // pin synchronisers and edge history
    always @(posedge aclk) begin
        if (!aresetn) begin
            trg_sync_q <= 2'b11;
            cin_sync_q <= 2'b11;
            trg_prev_q <= 1'b1;
            cin_prev_q <= 1'b1;
            div_q <= 1'b0;
        end else begin
            trg_sync_q <= {trg_sync_q[0], ext_trigger_pin};
            cin_sync_q <= {cin_sync_q[0], count_input_pin};
            trg_prev_q <= trg_sync_q[1];
            cin_prev_q <= cin_sync_q[1];
            div_q <= run ? ~div_q : 1'b0;
        end
    end

    // baud tick routing
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            rx_baud_tick <= rclk_sel ? ovf : timer1_overflow;
            tx_baud_tick <= tx_baud_source_select_sel ? ovf : timer1_overflow;
        end
    end

    // counter, reload register and control register
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TMR2_RST_BYTE;
            cnt_q <= `TMR2_RST_CNT;
            rc_q <= `TMR2_RST_CNT;
        end else begin
            // software writes first, hardware events override
            if (wr_go && wr_ok && wstrb_q) begin
                case (awaddr_q)
                    `TMR2_OFF_CTRL: ctrl_q <= wdata_q;
                    `TMR2_OFF_RCL: rc_q[7:0] <= wdata_q;
                    `TMR2_OFF_RCH: rc_q[15:8] <= wdata_q;
                    `TMR2_OFF_CNTL: cnt_q[7:0] <= wdata_q;
                    `TMR2_OFF_CNTH: cnt_q[15:8] <= wdata_q;
                    default: ctrl_q <= ctrl_q;
                endcase
            end
            if (reload) begin
                cnt_q <= rc_q;
            end else if (tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
            if (capture) begin
                rc_q <= cnt_q;
            end
            if (ovf && !baud_mode) begin
                ctrl_q[`TMR2_BIT_TF] <= 1'b1;
            end
            if (trig_evt) begin
                ctrl_q[`TMR2_BIT_EXF] <= 1'b1;
            end
        end
    end

    // axi write slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMR2_RESP_OK;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= `TMR2_RST_BYTE;
            wdata_q <= `TMR2_RST_BYTE;
            wstrb_q <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `TMR2_RESP_OK : `TMR2_RESP_ERR;
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read slave
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TMR2_RESP_OK;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= tmr2_hit(s_axi_araddr) ? `TMR2_RESP_OK : `TMR2_RESP_ERR;
                case (s_axi_araddr)
                    `TMR2_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl_q};
                    `TMR2_OFF_RCL: s_axi_rdata <= {24'h000000, rc_q[7:0]};
                    `TMR2_OFF_RCH: s_axi_rdata <= {24'h000000, rc_q[15:8]};
                    `TMR2_OFF_CNTL: s_axi_rdata <= {24'h000000, cnt_q[7:0]};
                    `TMR2_OFF_CNTH: s_axi_rdata <= {24'h000000, cnt_q[15:8]};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // tmr2_ctrl

/* verilog/tmr2_map.vh */
// register offsets, field positions and reset values for the timer-2 block
// assumes byte addresses on a 32-bit axi4-lite bus, one byte offset per register
`ifndef TMR2_MAP_VH
`define TMR2_MAP_VH
`define TMR2_ADDR_W 8
`define TMR2_OFF_CTRL 8'hC8
`define TMR2_OFF_RCL 8'hCA
`define TMR2_OFF_RCH 8'hCB
`define TMR2_OFF_CNTL 8'hCC
`define TMR2_OFF_CNTH 8'hCD
`define TMR2_BIT_TF 7
`define TMR2_BIT_EXF 6
`define TMR2_BIT_RCLK 5
`define TMR2_BIT_TX_BAUD_SOURCE_SELECT 4
`define TMR2_BIT_EXEN 3
`define TMR2_BIT_RUN 2
`define TMR2_BIT_CT 1
`define TMR2_BIT_CP 0
`define TMR2_RST_BYTE 8'h00
`define TMR2_RST_CNT 16'h0000
`define TMR2_CNT_MAX 16'hFFFF
`define TMR2_RESP_OK 2'b00
`define TMR2_RESP_ERR 2'b10
`endif

/* test/tmr2_props.sv */
// bus handshake checker for the timer-2 block
// assumes it is bound onto tmr2_ctrl
`timescale 1ns/10ps
module tmr2_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus signals
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_rdone; s_axi_rvalid && s_axi_rready; endsequence
    sequence s_rwait; s_axi_rvalid && !s_axi_rready; endsequence
    sequence s_bwait; s_axi_bvalid && !s_axi_bready; endsequence
    sequence s_rerr; s_axi_rvalid && s_axi_rresp == 2'h2; endsequence
    a_rd_answer: assert property (s_rd |=> s_axi_rvalid) else $error("no read data");
    a_r_stands: assert property (s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_r_release: assert property (s_rdone |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_b_stands: assert property (s_bwait |=> s_axi_bvalid) else $error("bvalid dropped");
    a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_ar_pulse: assert property (s_rd |=> !s_axi_arready) else $error("arready held");
    a_resp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("bad rresp");
    a_err_zero: assert property (s_rerr |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
endmodule // tmr2_props
bind tmr2_ctrl tmr2_props u_tmr2_props (.*);

/* test/tmr2_pins.sv */
// pin and other-timer model for the timer-2 block
// assumes pins idle high and one shared clock
`timescale 1ns/10ps
module tmr2_pins (
    // clock in, pins out
    input wire aclk,
    output reg ext_trigger_pin,
    output reg count_input_pin,
    output reg timer1_overflow
);
    initial {ext_trigger_pin, count_input_pin, timer1_overflow} = 3'h6;
    // one low pulse, long enough for the synchroniser
    task fall(input bit trig);
        repeat (2) begin
            @(posedge aclk);
            if (trig) ext_trigger_pin <= ~ext_trigger_pin;
            else count_input_pin <= ~count_input_pin;
            repeat (3) @(posedge aclk);
        end
    endtask
    // one-cycle overflow of the other timer
    task t1_pulse();
        @(posedge aclk);
        timer1_overflow <= 1'h1;
        @(posedge aclk);
        timer1_overflow <= 1'h0;
    endtask
endmodule // tmr2_pins

/* test/timer2_capture_reload_control_bench.sv */
// self-checking bench for the timer-2 block
// assumes tmr2_ctrl and tmr2_pins on one 100 MHz clock
`timescale 1ns/10ps
module timer2_capture_reload_control_bench;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rd;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [1:0] rs, ws;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire rx_baud_tick, tx_baud_tick, ext_trigger_pin, count_input_pin, timer1_overflow;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int n_fail = 0, n_checks = 0, cyc = 0, n_baud = 0, base = 0;
    // {resp, write, addr, data}
    logic [23:0] rows [12] = '{24'h00C800, 24'h00CA00, 24'h00CC00, 24'h00CD00, 24'h200000,
        24'h01CA34, 24'h01CB12, 24'h00CA34, 24'h01CCFE, 24'h01CDFF, 24'h00CCFE, 24'h2100AA};
    tmr2_ctrl u_tmr2_ctrl (.*);
    tmr2_pins u_tmr2_pins (.*);
    initial forever #5 aclk = ~aclk;
    task chk(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // bus write, address and data offered together; bready raised late so bvalid must hold
    task wr(input logic [7:0] a, d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h1;
        @(posedge aclk);
        ws = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    // bus read; rready raised late so read data must hold, taken at the handshake edge
    task rd_(input logic [7:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h1;
        @(posedge aclk);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
    task complete_run();
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard and tally of baud ticks
    always @(posedge aclk) begin
        cyc++;
        n_baud += rx_baud_tick + tx_baud_tick;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i][16]) begin
                wr(rows[i][15:8], rows[i][7:0]);
                chk(ws, rows[i][21:20]);
            end else begin
                rd_(rows[i][15:8]);
                chk(rd, {24'h0, rows[i][7:0]});
                chk(rs, rows[i][21:20]);
            end
        end
        wr(8'hC8, 8'h04);
        repeat (10) @(posedge aclk);
        rd_(8'hC8);
        chk(rd, 32'h84);
        rd_(8'hCD);
        chk(rd, 32'h12);
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h77);
        repeat (8) @(posedge aclk);
        rd_(8'hCC);
        chk(rd, 32'h77);
        // timer mode from zero: 26 clocks between the two run writes give 13 ticks
        wr(8'hCD, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h04);
        repeat (20) @(posedge aclk);
        wr(8'hC8, 8'h00);
        rd_(8'hCC);
        chk(rd, 32'h0D);
        wr(8'hCC, 8'h05);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h0F);
        repeat (3) u_tmr2_pins.fall(0);
        repeat (5) @(posedge aclk);
        rd_(8'hCC);
        chk(rd, 32'h08);
        u_tmr2_pins.fall(1);
        repeat (5) @(posedge aclk);
        rd_(8'hCA);
        chk(rd, 32'h08);
        rd_(8'hC8);
        chk(rd, 32'h4F);
        // capture overwrote the reload value; give it a high byte to reload from
        wr(8'hCB, 8'h12);
        wr(8'hC8, 8'h0E);
        u_tmr2_pins.fall(1);
        repeat (5) @(posedge aclk);
        rd_(8'hCD);
        chk(rd, 32'h12);
        wr(8'hC8, 8'h00);
        u_tmr2_pins.t1_pulse();
        #1 chk({rx_baud_tick, tx_baud_tick}, 2'h3);
        wr(8'hC8, 8'h30);
        u_tmr2_pins.t1_pulse();
        #1 chk({rx_baud_tick, tx_baud_tick}, 2'h0);
        // baud mode: capture select and trigger ignored, overflow reloads, no flags
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'hFF);
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        base = n_baud;
        wr(8'hC8, 8'h3D);
        repeat (10) @(posedge aclk);
        u_tmr2_pins.fall(1);
        repeat (5) @(posedge aclk);
        rd_(8'hCD);
        chk(rd, 32'h12);
        rd_(8'hCA);
        chk(rd, 32'h34);
        rd_(8'hC8);
        chk(rd, 32'h3D);
        chk(n_baud - base, 32'h2);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd_(8'hCD);
        chk(rd, 32'h00);
        complete_run();
    end
endmodule // timer2_capture_reload_control_bench
